// *** cirs_pkg.sv ***
// Shared constants, types and helpers of the comparator interrupt and reset status registers
package cirs_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PORT_W = 5;
  localparam int CMP_N = 2;
  localparam int MODE_W = 3;

  // ********************************************************************
  // File addresses, bank select in bit 7
  // ********************************************************************
  localparam logic [ADDR_W-1:0] ADDR_PORTA = 8'h05;
  localparam logic [ADDR_W-1:0] ADDR_FLAG = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_CMP_CTRL = 8'h1F;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = 8'h8C;
  localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE = 8'h8E;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int CMP_IRQ_BIT = 6;
  localparam int POR_BIT = 1;
  localparam int BOR_BIT = 0;
  localparam int CMP_OUT_LSB = 6;
  localparam int MODE_LSB = 0;
  localparam int PIN_A = 3;
  localparam int PIN_B = 4;

  // ********************************************************************
  // Encodings and reset values
  // ********************************************************************
  localparam logic [MODE_W-1:0] MODE_PIN_OUT = 3'h6;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic FLAG_RST = 1'h0;
  localparam logic ENABLE_RST = 1'h0;
  localparam logic POR_AFTER_POWER_ON = 1'h0;
  localparam logic BOR_AFTER_POWER_ON = 1'h1;
  localparam logic BOR_AFTER_BROWNOUT = 1'h0;

  typedef logic [ADDR_W-1:0] cirs_addr_t;
  typedef logic [DATA_W-1:0] cirs_byte_t;

  // Byte with a single bit placed at a position, all others zero
  function automatic cirs_byte_t cirs_bit_byte(input int pos, input logic v);
    cirs_byte_t b;
    b = 8'h00;
    b[pos] = v;
    return b;
  endfunction

endpackage

// *** cirs_sync_if.sv ***
// Carrier between an asynchronous input group and its synchroniser
`timescale 1ns/1ps
interface cirs_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_mp(input raw, output clean);
  modport user_mp(output raw, input clean);
endinterface // cirs_sync_if

// *** cirs_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cirs_sync3 #(
  parameter int W = 1
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  cirs_sync_if.sync_mp link
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] clean_reg;
  logic [W-1:0] agree;
  logic [W-1:0] clean_next;

  // A bit only moves once stages two and three agree, so a glitch
  // caught by one stage alone never reaches the user
  assign agree = ~(s2_reg ^ s3_reg);
  assign clean_next = (s2_reg & agree) | (clean_reg & ~agree);
  assign link.clean = clean_reg;

  // Stage one feeds stage two only
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      clean_reg <= '0;
    end else begin
      s1_reg <= link.raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      clean_reg <= clean_next;
    end
  end

  a_filter_agree_pass: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (s2_reg == s3_reg) |=> (clean_reg == $past(s2_reg)))
    else $error("synchroniser output ignored agreeing stages");

endmodule // cirs_sync3

// *** cirs_regs.sv ***
// Comparator interrupt, comparator output and reset cause register group
// Summary of operation
// - Enable register at 8Ch, bit 6 enables comparator interrupt, resets to 0.
// - Unimplemented addresses and unimplemented bit positions read as zero.
// - Flag register at 0Ch, bit 6 read-write, resets 0, set on comparator change.
// - Flags set on their condition regardless of individual or global enable.
// - Reset cause bit 1 reads 0 after power-on; software sets it to 1.
// - Reset cause bit 0 reads 0 after brown-out, else 1; software sets it.
// - Brown-out bit undefined after power-on; software sets then checks later. Power-on loads it with 1 here.
// - Brown-out bit value is unspecified while the brown-out circuit is disabled.
// - Reset cause bits 7 to 2 are unimplemented and read zero.
// - Comparator output bits read-only in comparator control register.
// - Mode 110 routes raw comparator outputs to port A pins 3 and 4.
// - Port A direction bits still gate those pin drivers in that mode.
// - Port data reads return 0 for pins configured as analog inputs.
// - Configuration bit enables brown-out reset circuit when set.
`timescale 1ns/1ps
module cirs_regs (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] file_addr_i,
  input wire logic file_wr_en_i,
  input wire logic [7:0] file_wr_data_i,
  input wire logic file_rd_en_i,
  output logic [7:0] file_rd_data_o,
  input wire logic [1:0] cmp_out_i,
  input wire logic [4:0] porta_pin_i,
  input wire logic [4:0] porta_analog_i,
  input wire logic [4:0] porta_direction_i,
  input wire logic [4:0] porta_latch_i,
  input wire logic por_cause_i,
  input wire logic brownout_cause_i,
  input wire logic brownout_circuit_en_i,
  output logic comparator_irq_o,
  output logic [2:0] comparator_mode_sel_o,
  output logic porta_pin3_o,
  output logic porta_pin3_oe_o,
  output logic porta_pin4_o,
  output logic porta_pin4_oe_o
);

  // ********************************************************************
  // Input synchronisers
  // ********************************************************************
  cirs_sync_if #(.W(cirs_pkg::CMP_N)) cmp_link ();
  cirs_sync_if #(.W(cirs_pkg::PORT_W)) pin_link ();

  assign cmp_link.raw = cmp_out_i;
  assign pin_link.raw = porta_pin_i;

  cirs_sync3 #(.W(cirs_pkg::CMP_N)) u_cmp_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .link(cmp_link.sync_mp)
  );

  cirs_sync3 #(.W(cirs_pkg::PORT_W)) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .link(pin_link.sync_mp)
  );

  // ********************************************************************
  // State
  // ********************************************************************
  logic flag_reg;
  logic flag_next;
  logic enable_reg;
  logic enable_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic [1:0] cmp_seen_reg;
  logic [1:0] cmp_seen_next;
  logic por_reg;
  logic por_next;
  logic bor_reg;
  logic bor_next;
  logic release_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  // ********************************************************************
  // Address decode
  // ********************************************************************
  logic hit_porta;
  logic hit_flag;
  logic hit_cmp_ctrl;
  logic hit_enable;
  logic hit_cause;
  logic hit_any;
  logic wr_flag;
  logic wr_enable;
  logic wr_cmp_ctrl;
  logic wr_cause;
  logic rd_cmp_ctrl;

  // Full eight-bit compare, so the bank bit is part of every decode
  assign hit_porta = (file_addr_i == cirs_pkg::ADDR_PORTA);
  assign hit_flag = (file_addr_i == cirs_pkg::ADDR_FLAG);
  assign hit_cmp_ctrl = (file_addr_i == cirs_pkg::ADDR_CMP_CTRL);
  assign hit_enable = (file_addr_i == cirs_pkg::ADDR_ENABLE);
  assign hit_cause = (file_addr_i == cirs_pkg::ADDR_RESET_CAUSE);
  assign hit_any = hit_porta | hit_flag | hit_cmp_ctrl | hit_enable | hit_cause;
  assign wr_flag = file_wr_en_i & hit_flag;
  assign wr_enable = file_wr_en_i & hit_enable;
  assign wr_cmp_ctrl = file_wr_en_i & hit_cmp_ctrl;
  assign wr_cause = file_wr_en_i & hit_cause;
  assign rd_cmp_ctrl = file_rd_en_i & hit_cmp_ctrl;

  // ********************************************************************
  // Comparator change flag and interrupt request
  // ********************************************************************
  logic cmp_changed;
  logic [1:0] cmp_now;

  assign cmp_now = cmp_link.clean;
  assign cmp_changed = (cmp_now != cmp_seen_reg);
  // flag set over write; enable plays no part in setting
  assign flag_next = cmp_changed ? 1'h1 :
                     (wr_flag ? file_wr_data_i[cirs_pkg::CMP_IRQ_BIT] : flag_reg);
  // reading the control register re-arms the compare
  assign cmp_seen_next = rd_cmp_ctrl ? cmp_now : cmp_seen_reg;
  assign enable_next = wr_enable ? file_wr_data_i[cirs_pkg::CMP_IRQ_BIT] : enable_reg;
  // request while flag and enable both set
  assign comparator_irq_o = flag_reg & enable_reg;

  // Mode field only; output bit positions ignore writes
  // outputs not writable
  assign mode_next = wr_cmp_ctrl ?
                     file_wr_data_i[cirs_pkg::MODE_LSB +: cirs_pkg::MODE_W] : mode_reg;
  assign comparator_mode_sel_o = mode_reg;

  // Register file proper
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag_reg <= cirs_pkg::FLAG_RST;
      enable_reg <= cirs_pkg::ENABLE_RST;
      mode_reg <= cirs_pkg::MODE_RST;
      cmp_seen_reg <= 2'h0;
      rd_data_reg <= 8'h00;
    end else begin
      flag_reg <= flag_next;
      enable_reg <= enable_next;
      mode_reg <= mode_next;
      cmp_seen_reg <= cmp_seen_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // ********************************************************************
  // Reset cause indicators
  // ********************************************************************
  logic bor_event;

  // brown-out only counts while its circuit is enabled
  assign bor_event = brownout_cause_i & brownout_circuit_en_i;

  // The cause bits must survive non power-on resets, so they carry no
  // asynchronous reset; the first edge after release loads the cause
  // power-on clears indicator; brown-out bit defined as 1 then
  assign por_next = (release_reg & por_cause_i) ? cirs_pkg::POR_AFTER_POWER_ON :
                    (wr_cause ? file_wr_data_i[cirs_pkg::POR_BIT] : por_reg);
  // brown-out clears indicator; disabled circuit leaves it as is
  assign bor_next = (release_reg & por_cause_i) ? cirs_pkg::BOR_AFTER_POWER_ON :
                    (release_reg & bor_event) ? cirs_pkg::BOR_AFTER_BROWNOUT :
                    (wr_cause ? file_wr_data_i[cirs_pkg::BOR_BIT] : bor_reg);

  // High through reset and at the first edge after reset release
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      release_reg <= 1'h1;
    end else begin
      release_reg <= 1'h0;
    end
  end

  // Cause bits, clocked without reset
  always_ff @(posedge ref_clk_i) begin
    por_reg <= por_next;
    bor_reg <= bor_next;
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  logic [7:0] rd_porta;
  logic [7:0] rd_flag;
  logic [7:0] rd_enable;
  logic [7:0] rd_cmp;
  logic [7:0] rd_cause;
  logic [7:0] rd_value;
  logic [4:0] pin_digital;

  assign pin_digital = pin_link.clean & ~porta_analog_i;
  assign rd_porta = {3'h0, pin_digital};
  assign rd_flag = cirs_pkg::cirs_bit_byte(cirs_pkg::CMP_IRQ_BIT, flag_reg);
  assign rd_enable = cirs_pkg::cirs_bit_byte(cirs_pkg::CMP_IRQ_BIT, enable_reg);
  assign rd_cmp = cirs_pkg::cirs_bit_byte(cirs_pkg::CMP_OUT_LSB, cmp_now[0]) |
                  cirs_pkg::cirs_bit_byte(cirs_pkg::CMP_OUT_LSB + 1, cmp_now[1]) |
                  {5'h00, mode_reg};
  assign rd_cause = cirs_pkg::cirs_bit_byte(cirs_pkg::POR_BIT, por_reg) |
                    cirs_pkg::cirs_bit_byte(cirs_pkg::BOR_BIT, bor_reg);
  assign rd_value = hit_porta ? rd_porta :
                    hit_flag ? rd_flag :
                    hit_enable ? rd_enable :
                    hit_cmp_ctrl ? rd_cmp :
                    hit_cause ? rd_cause : 8'h00;
  // Read data holds between reads so a slow core can sample late
  assign rd_data_next = file_rd_en_i ? rd_value : rd_data_reg;
  assign file_rd_data_o = rd_data_reg;

  // ********************************************************************
  // Port A pin routing
  // ********************************************************************
  logic pin_mode;

  assign pin_mode = (mode_reg == cirs_pkg::MODE_PIN_OUT);
  // raw comparator outputs, deliberately not synchronised
  assign porta_pin3_o = pin_mode ? cmp_out_i[0] : porta_latch_i[cirs_pkg::PIN_A];
  assign porta_pin4_o = pin_mode ? cmp_out_i[1] : porta_latch_i[cirs_pkg::PIN_B];
  // direction bit still gates driver (1 means input)
  assign porta_pin3_oe_o = ~porta_direction_i[cirs_pkg::PIN_A];
  assign porta_pin4_oe_o = ~porta_direction_i[cirs_pkg::PIN_B];

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_enable_on;
    wr_enable && file_wr_data_i[cirs_pkg::CMP_IRQ_BIT] && !wr_flag;
  endsequence

  sequence s_change_seen;
    cmp_changed ##1 flag_reg;
  endsequence

  a_enable_write_store: assert property (
    wr_enable |=> (enable_reg == $past(file_wr_data_i[cirs_pkg::CMP_IRQ_BIT])))
    else $error("enable bit did not take written value");

  a_unmapped_read_zero: assert property (
    (file_rd_en_i && !hit_any) |=> (file_rd_data_o == 8'h00))
    else $error("unmapped address read non-zero");

  a_flag_read_mask: assert property (
    (file_rd_en_i && (hit_flag || hit_enable)) |=> ((file_rd_data_o & 8'hBF) == 8'h00))
    else $error("unimplemented flag or enable bit read non-zero");

  a_flag_set_change: assert property (
    cmp_changed |=> flag_reg)
    else $error("comparator change did not set flag");

  a_flag_set_wins: assert property (
    (cmp_changed && wr_flag && !file_wr_data_i[cirs_pkg::CMP_IRQ_BIT]) |=> flag_reg)
    else $error("clear beat a simultaneous change");

  a_flag_sticks: assert property (
    (flag_reg && !wr_flag) |=> flag_reg)
    else $error("flag dropped without a write");

  a_irq_after_enable: assert property (
    (s_enable_on and flag_reg) |=> comparator_irq_o)
    else $error("no request with flag and enable set");

  a_irq_needs_enable: assert property (
    s_change_seen |-> (comparator_irq_o == enable_reg))
    else $error("request does not follow enable");

  a_rearm_on_read: assert property (
    rd_cmp_ctrl |=> (cmp_seen_reg == $past(cmp_now)))
    else $error("control read did not latch outputs");

  a_por_indicator: assert property (
    (release_reg && por_cause_i) |=> (!por_reg && bor_reg))
    else $error("power-on did not load cause bits");

  a_bor_indicator: assert property (
    (release_reg && !por_cause_i && bor_event) |=> !bor_reg)
    else $error("brown-out did not clear indicator");

  a_bor_disabled_hold: assert property (
    (release_reg && !por_cause_i && !brownout_circuit_en_i) |=> $stable(bor_reg))
    else $error("disabled brown-out changed indicator");

  a_cause_high_zero: assert property (
    (file_rd_en_i && hit_cause) |=> (file_rd_data_o[7:2] == 6'h00))
    else $error("reset cause upper bits non-zero");

  a_cmp_out_readonly: assert property (
    (file_rd_en_i && hit_cmp_ctrl) |=>
      (file_rd_data_o[cirs_pkg::CMP_OUT_LSB +: 2] == $past(cmp_now)))
    else $error("comparator output bits not the live outputs");

  a_pin_routing: assert property (
    (wr_cmp_ctrl && (file_wr_data_i[2:0] == cirs_pkg::MODE_PIN_OUT)) |=>
      (porta_pin3_o == cmp_out_i[0]) && (porta_pin4_o == cmp_out_i[1]))
    else $error("comparator outputs not routed to pins");

  a_pin_enable_gate: assert property (
    pin_mode |-> (porta_pin3_oe_o != porta_direction_i[cirs_pkg::PIN_A]) &&
                 (porta_pin4_oe_o != porta_direction_i[cirs_pkg::PIN_B]))
    else $error("direction bits do not gate pin drivers");

  a_analog_read_zero: assert property (
    (file_rd_en_i && hit_porta) |=> ((file_rd_data_o[4:0] & $past(porta_analog_i)) == 5'h00))
    else $error("analog pin read non-zero");

endmodule // cirs_regs

// *** cirs_core_model.sv ***
// Processor core model that reads and writes the banked file registers
`timescale 1ns/1ps
module cirs_core_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] file_rd_data_i,
  output logic [7:0] file_addr_o,
  output logic file_wr_en_o,
  output logic [7:0] file_wr_data_o,
  output logic file_rd_en_o
);
  // ********************************************************************
  // Idle bus
  // ********************************************************************
  // Strobes low from time zero so nothing is taken during reset
  initial begin
    file_addr_o = 8'h00;
    file_wr_en_o = 1'b0;
    file_wr_data_o = 8'h00;
    file_rd_en_o = 1'b0;
  end

  // ********************************************************************
  // Transfers
  // ********************************************************************
  // One byte write; the strobe stands for exactly one taking edge
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    file_addr_o = addr;
    file_wr_data_o = data;
    file_wr_en_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    file_wr_en_o = 1'b0;
    file_wr_data_o = ~data; // Released data shows a changed value, not the last one
  endtask

  // One byte read; the registered answer is settled just after the taking edge
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge ref_clk_i);
    #1;
    file_addr_o = addr;
    file_rd_en_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    file_rd_en_o = 1'b0;
    data = file_rd_data_i;
    file_addr_o = ~addr; // Address no longer qualified, so it moves
  endtask
endmodule // cirs_core_model

// *** tb_top.sv ***
// Self-checking testbench of the comparator interrupt and reset status registers
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i;
  logic reset_n_i;
  logic [7:0] file_addr;
  logic file_wr_en;
  logic [7:0] file_wr_data;
  logic file_rd_en;
  logic [7:0] file_rd_data;
  logic [1:0] cmp_out;
  logic [4:0] porta_pin;
  logic [4:0] porta_analog;
  logic [4:0] porta_direction;
  logic [4:0] porta_latch;
  logic por_cause;
  logic brownout_cause;
  logic brownout_circuit_en;
  logic comparator_irq;
  logic [2:0] mode_sel;
  logic pin3;
  logic pin3_oe;
  logic pin4;
  logic pin4_oe;
  int fails = 0;
  int check_count = 0;

  cirs_regs cirs_regs_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .file_addr_i(file_addr), .file_wr_en_i(file_wr_en), .file_wr_data_i(file_wr_data),
    .file_rd_en_i(file_rd_en), .file_rd_data_o(file_rd_data), .cmp_out_i(cmp_out),
    .porta_pin_i(porta_pin), .porta_analog_i(porta_analog),
    .porta_direction_i(porta_direction), .porta_latch_i(porta_latch),
    .por_cause_i(por_cause), .brownout_cause_i(brownout_cause),
    .brownout_circuit_en_i(brownout_circuit_en), .comparator_irq_o(comparator_irq),
    .comparator_mode_sel_o(mode_sel), .porta_pin3_o(pin3), .porta_pin3_oe_o(pin3_oe),
    .porta_pin4_o(pin4), .porta_pin4_oe_o(pin4_oe));

  cirs_core_model cirs_core_model_i (.ref_clk_i(ref_clk_i), .file_rd_data_i(file_rd_data),
    .file_addr_o(file_addr), .file_wr_en_o(file_wr_en), .file_wr_data_o(file_wr_data),
    .file_rd_en_o(file_rd_en));

  // ********************************************************************
  // Clock, verdict and watchdog
  // ********************************************************************
  // Core clock at 250 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The whole sequence needs about 110 cycles; this limit is generous
  initial begin
    #40000;
    fails++;
    close_out();
  end

  // ********************************************************************
  // Compare helpers
  // ********************************************************************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    cirs_core_model_i.read_reg(addr, data);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    cirs_core_model_i.write_reg(addr, data);
  endtask

  // Reset pulse with held causes; two edges after release before any request
  task automatic do_reset(input logic por, input logic bor, input logic en);
    @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b0;
    por_cause = por;
    brownout_cause = bor;
    brownout_circuit_en = en;
    repeat (4) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    por_cause = 1'b0;
    brownout_cause = 1'b0;
  endtask

  // ********************************************************************
  // Scenarios
  // ********************************************************************
  // Power-on values, unmapped reads and masked writes
  task automatic t_reset_map();
    logic [7:0] d;
    rd(cirs_pkg::ADDR_ENABLE, d);
    chk8("enable after reset", 8'h00, d);
    rd(cirs_pkg::ADDR_FLAG, d);
    chk8("flag after reset", 8'h00, d);
    rd(cirs_pkg::ADDR_RESET_CAUSE, d);
    chk8("cause after power-on", 8'h01, d);
    rd(8'h0D, d);
    chk8("unmapped 0Dh", 8'h00, d);
    wr(8'h8D, 8'hFF);
    rd(8'h8D, d);
    chk8("unmapped 8Dh", 8'h00, d);
    wr(cirs_pkg::ADDR_RESET_CAUSE, 8'hFF);
    rd(cirs_pkg::ADDR_RESET_CAUSE, d);
    chk8("cause bits 7-2", 8'h03, d);
  endtask

  // Flag sets whatever the enable, request follows flag and enable
  task automatic t_flag_irq();
    logic [7:0] d;
    // Clear the flag before enabling, as software should
    wr(cirs_pkg::ADDR_FLAG, 8'h00);
    cmp_out = 2'b01;
    repeat (8) @(posedge ref_clk_i);
    #1;
    rd(cirs_pkg::ADDR_FLAG, d);
    chk8("flag with enable off", 8'h40, d);
    chk1("request while disabled", 1'b0, comparator_irq);
    wr(cirs_pkg::ADDR_ENABLE, 8'hFF);
    rd(cirs_pkg::ADDR_ENABLE, d);
    chk8("enable readback", 8'h40, d);
    chk1("request on", 1'b1, comparator_irq);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk1("flag stays set", 1'b1, comparator_irq);
    rd(cirs_pkg::ADDR_CMP_CTRL, d);
    chk8("outputs in control", 8'h40, d);
    wr(cirs_pkg::ADDR_FLAG, 8'h00);
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk1("request after clear", 1'b0, comparator_irq);
    cmp_out = 2'b10;
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk1("request on new change", 1'b1, comparator_irq);
    // A clear that lands while the change is still pending must lose
    wr(cirs_pkg::ADDR_FLAG, 8'h00);
    rd(cirs_pkg::ADDR_FLAG, d);
    chk8("set beats clear", 8'h40, d);
    rd(cirs_pkg::ADDR_CMP_CTRL, d);
    wr(cirs_pkg::ADDR_FLAG, 8'h00);
    wr(cirs_pkg::ADDR_ENABLE, 8'h00);
  endtask

  // Output routing in mode 110 with direction gating, read-only outputs
  task automatic t_routing();
    logic [7:0] d;
    wr(cirs_pkg::ADDR_CMP_CTRL, 8'hFE);
    rd(cirs_pkg::ADDR_CMP_CTRL, d);
    chk8("control write masked", 8'h86, d);
    chk8("mode output", 8'h06, {5'h00, mode_sel});
    for (int i = 0; i < 4; i++) begin
      // Drive one step after an edge so the synchroniser never races it
      @(posedge ref_clk_i);
      #1;
      cmp_out = i[1:0];
      porta_direction = {i[0], 1'b0, 3'h0};
      porta_latch = ~{i[1:0], 3'h0};
      #1;
      chk1("pin3 level", i[0], pin3);
      chk1("pin4 level", i[1], pin4);
      chk1("pin4 enable", ~i[0], pin4_oe);
      chk1("pin3 enable", 1'b1, pin3_oe);
    end
    wr(cirs_pkg::ADDR_CMP_CTRL, 8'h00);
    #1;
    chk1("pin3 follows latch", porta_latch[3], pin3);
  endtask

  // Port data reads zero on analog pins
  task automatic t_analog();
    logic [7:0] d;
    @(posedge ref_clk_i);
    #1;
    porta_pin = 5'h1F;
    porta_analog = 5'h0A;
    repeat (5) @(posedge ref_clk_i);
    rd(cirs_pkg::ADDR_PORTA, d);
    chk8("port A with analog pins", 8'h15, d);
  endtask

  // Brown-out reset, then a brown-out with the circuit disabled
  task automatic t_brownout();
    logic [7:0] d;
    do_reset(1'b0, 1'b1, 1'b1);
    rd(cirs_pkg::ADDR_RESET_CAUSE, d);
    chk8("cause after brown-out", 8'h02, d);
    // Software sets the indicator again; the check after the next reset masks it off and compares bits 7 to 1 only
    wr(cirs_pkg::ADDR_RESET_CAUSE, 8'h03);
    do_reset(1'b0, 1'b1, 1'b0);
    rd(cirs_pkg::ADDR_RESET_CAUSE, d);
    chk8("cause with circuit off", 8'h02, d & 8'hFE);
    rd(cirs_pkg::ADDR_ENABLE, d);
    chk8("enable after reset", 8'h00, d);
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    reset_n_i = 1'b0;
    cmp_out = 2'b00;
    porta_pin = 5'h00;
    porta_analog = 5'h00;
    porta_direction = 5'h1F;
    porta_latch = 5'h00;
    por_cause = 1'b1;
    brownout_cause = 1'b0;
    brownout_circuit_en = 1'b1;
    do_reset(1'b1, 1'b0, 1'b1);
    t_reset_map();
    t_flag_irq();
    t_routing();
    t_analog();
    t_brownout();
    close_out();
  end
endmodule // tb_top
